// *** rtl/uds_defines.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef UDS_DEFINES_SVH
`define UDS_DEFINES_SVH
`define UDS_OFS_FRAME    8'h00
`define UDS_OFS_STATE    8'h04
`define UDS_OFS_FADDR    8'h08
`define UDS_OFS_IEN_SET  8'h10
`define UDS_OFS_IEN_CLR  8'h14
`define UDS_OFS_MASK     8'h18
`define UDS_OFS_STATUS   8'h1c
`define UDS_OFS_ICLR     8'h20
`define UDS_FRAME_ERROR_BIT 16
`define UDS_FRAME_GOOD_BIT  17
`define UDS_FUNC_EN_BIT     8
`define UDS_BYTE_OK_BIT  4
`define UDS_BYTE_ERR_BIT 3
`define UDS_IRQ_SUSPEND  8
`define UDS_IRQ_RESUME   9
`define UDS_IRQ_SOF      11
`define UDS_IRQ_BUSRST   12
`define UDS_IRQ_WAKEUP   13
`define UDS_MASK_VALID   16'h2b3f
`define UDS_MASK_RESET   16'h1200
`define UDS_FADDR_RESET  32'h0000_0100
`define UDS_IDLE_MS      3
`define UDS_CLK_KHZ      250000
`define UDS_IDLE_CYCLES  (`UDS_IDLE_MS * `UDS_CLK_KHZ)
`endif

// *** rtl/uds_pkg.sv ***
// types shared by the device state and interrupt mask block
`default_nettype none
package uds_pkg;
  typedef struct packed {
    logic        sofPid;
    logic        sofEop;
    logic        sofCrcErr;
    logic [10:0] frameNum;
  } uds_sof_s;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } uds_bus_s;
  typedef enum logic [1:0] {
    ST_DEFAULT,
    ST_ADDRESSED,
    ST_CONFIGURED
  } uds_dev_e;
endpackage
`default_nettype wire

// *** rtl/uds_device_state.sv ***
// usb device frame capture, device state and interrupt mask logic
//
// Function
// R1: frame counter of 11 bits loaded at each start-of-frame end-of-packet
// R2: frame error set at SOF EOP on error, cleared on SOF PID
// R3: frame good set at SOF EOP without error, cleared on SOF PID
// R4: start-of-frame status raised on SOF PID, not waiting for EOP
// R5: byte view puts frame good at high bit 4, error at low bit 3
// R6: address enable reads state; write 1 enters; write 0 does nothing
// R7: firmware loads address and finishes status stage before address enable
// R8: configured bit reads state; write 1 enters, write 0 leaves
// R9: firmware sets configured only in address state after Set Configuration
// R10: seven-bit function address, firmware written, resets to zero
// R11: function enable reads back, cleared by 0, gates packet transfers
// R12: firmware sets function enable after host bus reset
// R13: enable register write 1 sets matching mask bit, write 0 ignored
// R14: disable register write 1 clears matching mask bits
// R15: mask bit 12 always reads 1 and cannot be masked
// R16: mask bit 1 means interrupt enabled, 0 means disabled
// R17: end-of-bus-reset status raised when bus reset finishes
// R18: suspend status raised after 3 ms with no bus activity
// R19: interrupt output high while a status bit and its mask are set
`include "uds_defines.svh"
`default_nettype none
module uds_device_state #(
  parameter int unsigned IDLE_CYCLES = `UDS_IDLE_CYCLES
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire uds_pkg::uds_bus_s bus,
  output var  logic [31:0]      rdata,
  input  wire uds_pkg::uds_sof_s sof,
  input  wire logic [5:0]       endpointIrq,
  input  wire logic             busActivity,
  input  wire logic             busResetDone,
  input  wire logic             resumeSeen,
  input  wire logic             wakeupSeen,
  output logic                  irq,
  output logic                  functionEnable,
  output logic [6:0]            deviceAddress,
  output logic                  configuredState,
  output logic                  addressState,
  output logic                  suspended,
  output logic [7:0]            frameHighByte,
  output logic [7:0]            frameLowByte
);
  logic [10:0]     frameCounter;
  logic            frameErrorFlag;
  logic            frameGoodFlag;
  uds_pkg::uds_dev_e devState;
  logic [15:0]     mask;
  logic [15:0]     status;
  logic [15:0]     events;
  logic [31:0]     idleCount;
  logic            idleHit;
  logic            wrFaddr;
  logic            wrState;
  localparam logic [31:0] FUNC_ADDR_RESET = `UDS_FADDR_RESET;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wrFaddr = bus.wr && hit(bus.addr, `UDS_OFS_FADDR);
  assign wrState = bus.wr && hit(bus.addr, `UDS_OFS_STATE);

  // frame capture
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frameCounter   <= 11'h000;
      frameErrorFlag <= 1'b0;
      frameGoodFlag  <= 1'b0;
    end else if (sof.sofPid) begin
      frameErrorFlag <= 1'b0; // [R2]
      frameGoodFlag  <= 1'b0; // [R3]
    end else if (sof.sofEop) begin
      frameCounter   <= sof.frameNum; // [R1]
      frameErrorFlag <= sof.sofCrcErr; // [R2]
      frameGoodFlag  <= !sof.sofCrcErr; // [R3]
    end
  end

  // byte-wide view of frame register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frameHighByte <= 8'h00;
      frameLowByte  <= 8'h00;
    end else begin
      frameHighByte <= {3'h0, frameGoodFlag, 1'b0, frameCounter[10:8]}; // [R5]
      frameLowByte  <= {frameCounter[7:4], frameErrorFlag,
                        frameCounter[2:0]}; // [R5]
    end
  end

  // device state: bus reset returns to default
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      devState <= uds_pkg::ST_DEFAULT;
    end else if (busResetDone) begin
      devState <= uds_pkg::ST_DEFAULT;
    end else if (wrState) begin
      case (devState)
        uds_pkg::ST_DEFAULT: begin
          if (bus.wdata[0]) begin
            devState <= bus.wdata[1] ? uds_pkg::ST_CONFIGURED
                                     : uds_pkg::ST_ADDRESSED; // [R6] [R8]
          end
        end
        uds_pkg::ST_ADDRESSED: begin
          if (bus.wdata[1]) begin
            devState <= uds_pkg::ST_CONFIGURED; // [R8] [R9]
          end
        end
        uds_pkg::ST_CONFIGURED: begin
          if (!bus.wdata[1]) begin
            devState <= uds_pkg::ST_ADDRESSED; // [R8] [R6]
          end
        end
        default: devState <= uds_pkg::ST_DEFAULT;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      addressState    <= 1'b0;
      configuredState <= 1'b0;
    end else begin
      addressState    <= (devState != uds_pkg::ST_DEFAULT); // [R6]
      configuredState <= (devState == uds_pkg::ST_CONFIGURED); // [R8]
    end
  end

  // function address and enable
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      deviceAddress  <= 7'h00; // [R10]
      functionEnable <= FUNC_ADDR_RESET[`UDS_FUNC_EN_BIT];
    end else if (wrFaddr) begin
      deviceAddress  <= bus.wdata[6:0]; // [R10] [R7]
      functionEnable <= bus.wdata[`UDS_FUNC_EN_BIT]; // [R11] [R12]
    end
  end

  // idle timer for suspend
  assign idleHit = (idleCount == IDLE_CYCLES - 1);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idleCount <= 32'h0;
      suspended <= 1'b0;
    end else if (busActivity) begin
      idleCount <= 32'h0;
      suspended <= 1'b0;
    end else if (!suspended) begin
      idleCount <= idleHit ? 32'h0 : idleCount + 32'h1;
      if (idleHit) begin
        suspended <= 1'b1; // [R18]
      end
    end
  end

  always_comb begin
    events = 16'h0000;
    events[5:0] = endpointIrq;
    events[`UDS_IRQ_SUSPEND] = !busActivity && !suspended && idleHit; // [R18]
    events[`UDS_IRQ_RESUME]  = resumeSeen;
    events[`UDS_IRQ_SOF]     = sof.sofPid; // [R4]
    events[`UDS_IRQ_BUSRST]  = busResetDone; // [R17]
    events[`UDS_IRQ_WAKEUP]  = wakeupSeen;
  end

  // sticky status, set wins over write-one clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status <= 16'h0000;
    end else begin
      if (bus.wr && hit(bus.addr, `UDS_OFS_ICLR)) begin
        status <= ((status & ~bus.wdata[15:0]) | events)
                  & (`UDS_MASK_VALID | 16'h1000);
      end else begin
        status <= (status | events) & (`UDS_MASK_VALID | 16'h1000);
      end
    end
  end

  // mask register, bus reset restores its reset value
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mask <= `UDS_MASK_RESET;
    end else if (busResetDone) begin
      mask <= `UDS_MASK_RESET;
    end else if (bus.wr && hit(bus.addr, `UDS_OFS_IEN_SET)) begin
      mask <= mask | (bus.wdata[15:0] & `UDS_MASK_VALID); // [R13] [R16]
    end else if (bus.wr && hit(bus.addr, `UDS_OFS_IEN_CLR)) begin
      mask <= (mask & ~(bus.wdata[15:0] & `UDS_MASK_VALID))
              | 16'h1000; // [R14] [R15]
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & (mask | 16'h1000)); // [R19] [R15]
    end
  end

  // read port, data one cycle after strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h0;
    end else if (bus.rd) begin
      case (bus.addr)
        `UDS_OFS_FRAME: begin
          rdata <= {14'h0, frameGoodFlag, frameErrorFlag, 5'h0,
                    frameCounter};
        end
        `UDS_OFS_STATE: begin
          rdata <= {30'h0, devState == uds_pkg::ST_CONFIGURED,
                    devState != uds_pkg::ST_DEFAULT};
        end
        `UDS_OFS_FADDR: rdata <= {23'h0, functionEnable, 1'b0, deviceAddress};
        `UDS_OFS_MASK: rdata <= {16'h0, mask | 16'h1000}; // [R15]
        `UDS_OFS_STATUS: rdata <= {16'h0, status};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  property p_frame_load;
    @(posedge clock) disable iff (!reset_n)
      sof.sofEop && !sof.sofPid |=> frameCounter == $past(sof.frameNum);
  endproperty
  a_frame_load: assert property (p_frame_load) // [R1]
    else $error("frame counter not loaded at eop");

  property p_err_flag;
    @(posedge clock) disable iff (!reset_n)
      sof.sofPid |=> !frameErrorFlag && !frameGoodFlag;
  endproperty
  a_err_flag: assert property (p_err_flag) // [R2]
    else $error("frame flags not cleared on pid");

  property p_good_flag;
    @(posedge clock) disable iff (!reset_n)
      sof.sofEop && !sof.sofPid |=> frameGoodFlag != frameErrorFlag;
  endproperty
  a_good_flag: assert property (p_good_flag) // [R3]
    else $error("frame good and error not exclusive");

  property p_sof_status;
    @(posedge clock) disable iff (!reset_n)
      sof.sofPid |=> status[`UDS_IRQ_SOF];
  endproperty
  a_sof_status: assert property (p_sof_status) // [R4]
    else $error("sof status not raised on pid");

  property p_addr_sticky;
    @(posedge clock) disable iff (!reset_n)
      devState != uds_pkg::ST_DEFAULT && !busResetDone
        |=> devState != uds_pkg::ST_DEFAULT;
  endproperty
  a_addr_sticky: assert property (p_addr_sticky) // [R6]
    else $error("address state left without reset");

  property p_mask12;
    @(posedge clock) disable iff (!reset_n)
      bus.rd && bus.addr == `UDS_OFS_MASK |=> rdata[12];
  endproperty
  a_mask12: assert property (p_mask12) // [R15]
    else $error("mask bit 12 read as zero");

  property p_ien;
    @(posedge clock) disable iff (!reset_n)
      bus.wr && bus.addr == `UDS_OFS_IEN_SET && bus.wdata[0] && !busResetDone
        |=> mask[0];
  endproperty
  a_ien: assert property (p_ien) // [R13]
    else $error("enable write did not set mask");

  property p_idr;
    @(posedge clock) disable iff (!reset_n)
      bus.wr && bus.addr == `UDS_OFS_IEN_CLR && bus.wdata[11]
        |=> !mask[11];
  endproperty
  a_idr: assert property (p_idr) // [R14]
    else $error("disable write did not clear mask");

  property p_irq;
    @(posedge clock) disable iff (!reset_n)
      |(status & (mask | 16'h1000)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) // [R19]
    else $error("interrupt not raised");

  property p_busrst;
    @(posedge clock) disable iff (!reset_n)
      busResetDone |=> status[`UDS_IRQ_BUSRST]
        && devState == uds_pkg::ST_DEFAULT;
  endproperty
  a_busrst: assert property (p_busrst) // [R17]
    else $error("bus reset end not recorded");

  property p_suspend;
    @(posedge clock) disable iff (!reset_n)
      !busActivity && !suspended && idleHit
        |=> suspended && status[`UDS_IRQ_SUSPEND];
  endproperty
  a_suspend: assert property (p_suspend) // [R18]
    else $error("suspend not entered after idle");

  property p_addr_enter;
    @(posedge clock) disable iff (!reset_n)
      wrState && bus.wdata[0] && !busResetDone
        |=> devState != uds_pkg::ST_DEFAULT;
  endproperty
  a_addr_enter: assert property (p_addr_enter) // [R6]
    else $error("address enable write ignored");

  property p_cfg;
    @(posedge clock) disable iff (!reset_n)
      wrState && !busResetDone && devState != uds_pkg::ST_DEFAULT
        |=> (devState == uds_pkg::ST_CONFIGURED) == $past(bus.wdata[1]);
  endproperty
  a_cfg: assert property (p_cfg) // [R8]
    else $error("configured bit write not applied");

  property p_faddr;
    @(posedge clock) disable iff (!reset_n)
      wrFaddr |=> deviceAddress == $past(bus.wdata[6:0])
        && functionEnable == $past(bus.wdata[`UDS_FUNC_EN_BIT]);
  endproperty
  a_faddr: assert property (p_faddr) // [R10] [R11]
    else $error("function address write not applied");

  property p_byte_view;
    @(posedge clock) disable iff (!reset_n)
      1'b1 |=> frameHighByte[`UDS_BYTE_OK_BIT] == $past(frameGoodFlag)
        && frameLowByte[`UDS_BYTE_ERR_BIT] == $past(frameErrorFlag);
  endproperty
  a_byte_view: assert property (p_byte_view) // [R5]
    else $error("byte view flags misplaced");

  c_sof: cover property (@(posedge clock) disable iff (!reset_n)
    sof.sofPid ##[1:20] sof.sofEop);
  c_cfg: cover property (@(posedge clock) disable iff (!reset_n)
    devState == uds_pkg::ST_CONFIGURED);
  c_irq: cover property (@(posedge clock) disable iff (!reset_n) irq);
  c_susp: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(suspended));
  c_busrst: cover property (@(posedge clock) disable iff (!reset_n)
    busResetDone ##2 irq);
endmodule
`default_nettype wire

// *** test/uds_host_model.sv ***
// host side model: frame start packets, bus idle, bus reset and resume
`default_nettype none
module uds_host_model (
  input  wire logic              clock,
  output var  uds_pkg::uds_sof_s sof,
  output logic                   busActivity,
  output logic                   busResetDone,
  output logic                   resumeSeen,
  output logic                   wakeupSeen
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sof = '{sofPid: 1'b0, sofEop: 1'b0, sofCrcErr: 1'b1, frameNum: 11'h555};
    busActivity = 1'b1;
    busResetDone = 1'b0;
    resumeSeen = 1'b0;
    wakeupSeen = 1'b0;
  end
  // pid first, fields only valid beside the end of packet
  task automatic send_sof(input logic [10:0] num, input logic err,
                          input int gap);
    @(posedge clock);
    sof.sofPid <= 1'b1;
    @(posedge clock);
    sof.sofPid <= 1'b0;
    repeat (gap) @(posedge clock);
    sof.sofEop <= 1'b1;
    sof.frameNum <= num;
    sof.sofCrcErr <= err;
    @(posedge clock);
    sof.sofEop <= 1'b0;
    sof.frameNum <= ~num;
    sof.sofCrcErr <= ~err;
  endtask
  task automatic go_idle(input int n);
    @(posedge clock);
    busActivity <= 1'b0;
    repeat (n) @(posedge clock);
    busActivity <= 1'b1;
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    busResetDone <= (k == 0);
    resumeSeen <= (k == 1);
    wakeupSeen <= (k == 2);
    @(posedge clock);
    busResetDone <= 1'b0;
    resumeSeen <= 1'b0;
    wakeupSeen <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the device state and interrupt mask block
`include "uds_defines.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  uds_pkg::uds_bus_s bus = '0;
  uds_pkg::uds_sof_s sof;
  logic [31:0] rdata, v, rv;
  logic [5:0] endpointIrq = 6'h00;
  logic busActivity, busResetDone, resumeSeen, wakeupSeen, irq;
  logic functionEnable, configuredState, addressState, suspended;
  logic [6:0] deviceAddress;
  logic [7:0] frameHighByte, frameLowByte;
  logic [15:0] expMask;
  int num_errors = 0;
  int compares = 0;
  int seed = 50;
  int k;
  always #2 clock = ~clock;
  uds_host_model u_uds_host_model (.clock(clock), .sof(sof),
    .busActivity(busActivity), .busResetDone(busResetDone),
    .resumeSeen(resumeSeen), .wakeupSeen(wakeupSeen));
  uds_device_state #(.IDLE_CYCLES(20)) u_uds_device_state (
    .clock(clock), .reset_n(reset_n), .bus(bus), .rdata(rdata), .sof(sof),
    .endpointIrq(endpointIrq), .busActivity(busActivity),
    .busResetDone(busResetDone), .resumeSeen(resumeSeen),
    .wakeupSeen(wakeupSeen), .irq(irq), .functionEnable(functionEnable),
    .deviceAddress(deviceAddress), .configuredState(configuredState),
    .addressState(addressState), .suspended(suspended),
    .frameHighByte(frameHighByte), .frameLowByte(frameLowByte));
  function automatic logic [31:0] exp_frame(input logic [10:0] n,
                                            input logic e);
    return {14'h0, !e, e, 5'h0, n};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [31:0] e, input logic [31:0] m);
    rd(a, rv);
    chk(n, e, rv & m);
  endtask
  task automatic irq_is(input string n, input logic e);
    repeat (2) @(posedge clock);
    #1 chk(n, {31'h0, e}, {31'h0, irq});
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #240000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    rchk("frame", `UDS_OFS_FRAME, 32'h0, '1);
    rchk("state", `UDS_OFS_STATE, 32'h0, '1);
    rchk("faddr", `UDS_OFS_FADDR, `UDS_FADDR_RESET, '1);
    rchk("mask", `UDS_OFS_MASK, 32'h1200, '1);
    rchk("unmapped", 8'h0c, 32'h0, '1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(`UDS_OFS_ICLR, 32'hffff);
      fork
        u_uds_host_model.send_sof(v[10:0], i[0], 8);
        begin
          repeat (4) @(posedge clock);
          rchk("sof status", `UDS_OFS_STATUS, 32'h800, 32'h800);
          rchk("pid flags", `UDS_OFS_FRAME, 32'h0, 32'h30000);
        end
      join
      rchk("frame", `UDS_OFS_FRAME, exp_frame(v[10:0], i[0]), '1);
      chk("hi byte", {31'h0, !i[0]}, {31'h0, frameHighByte[4]});
      chk("lo byte", {31'h0, i[0]}, {31'h0, frameLowByte[3]});
    end
    $display("test frames done");
    expMask = 16'h1200;
    for (int i = 0; i < 12; i++) begin
      v = $random(seed) & 32'hffff;
      wr(i[0] ? `UDS_OFS_IEN_CLR : `UDS_OFS_IEN_SET, v);
      if (i[0]) begin
        expMask &= ~(v[15:0] & `UDS_MASK_VALID);
      end else begin
        expMask |= v[15:0] & `UDS_MASK_VALID;
      end
      expMask[12] = 1'b1;
      rchk("mask", `UDS_OFS_MASK, {16'h0, expMask}, '1);
    end
    wr(`UDS_OFS_MASK, 32'h0);
    rchk("mask ro", `UDS_OFS_MASK, {16'h0, expMask}, '1);
    $display("test mask done");
    v = $random(seed);
    wr(`UDS_OFS_FADDR, {25'h0, v[6:0]});
    rchk("faddr", `UDS_OFS_FADDR, {25'h0, v[6:0]}, '1);
    chk("fen", 32'h0, {31'h0, functionEnable});
    chk("addr", {25'h0, v[6:0]}, {25'h0, deviceAddress});
    for (int i = 0; i < 5; i++) begin
      k = i;
      wr(`UDS_OFS_STATE, {30'h0, 2'(k == 2 ? 3 : (k == 1 || k == 3))});
      rchk("state", `UDS_OFS_STATE, {30'h0, 2'(k == 2 ? 2 : k > 0)},
           k == 2 ? 32'h2 : 32'h3);
      chk("addr pin", {31'h0, k != 0}, {31'h0, addressState});
      chk("cfg pin", {31'h0, k == 2}, {31'h0, configuredState});
    end
    $display("test state done");
    wr(`UDS_OFS_IEN_CLR, 32'hffff);
    wr(`UDS_OFS_ICLR, 32'hffff);
    k = {$random(seed)} % 6;
    @(posedge clock);
    endpointIrq <= 6'(1 << k);
    @(posedge clock);
    endpointIrq <= 6'h00;
    irq_is("irq masked", 1'b0);
    rchk("status", `UDS_OFS_STATUS, 32'(1 << k), 32'h3f);
    wr(`UDS_OFS_IEN_SET, 32'(1 << k));
    irq_is("irq on", 1'b1);
    wr(`UDS_OFS_ICLR, 32'(1 << k));
    irq_is("irq off", 1'b0);
    fork
      u_uds_host_model.go_idle(30);
      begin
        repeat (27) @(posedge clock);
        #1 chk("suspended", 32'h1, {31'h0, suspended});
      end
    join
    rchk("susp status", `UDS_OFS_STATUS, 32'h100, 32'h100);
    wr(`UDS_OFS_ICLR, 32'hffff);
    u_uds_host_model.pulse(0);
    irq_is("irq busrst", 1'b1);
    rchk("mask", `UDS_OFS_MASK, 32'h1200, '1);
    rchk("state", `UDS_OFS_STATE, 32'h0, '1);
    wr(`UDS_OFS_ICLR, 32'h0001);
    rchk("busrst kept", `UDS_OFS_STATUS, 32'h1000, 32'h1000);
    wr(`UDS_OFS_ICLR, 32'h1000);
    irq_is("irq clr", 1'b0);
    u_uds_host_model.pulse(1);
    irq_is("irq resume", 1'b1);
    u_uds_host_model.pulse(2);
    rchk("wakeup", `UDS_OFS_STATUS, 32'h2000, 32'h2000);
    wr(`UDS_OFS_FADDR, 32'h100);
    rchk("faddr", `UDS_OFS_FADDR, 32'h100, '1);
    chk("fen", 32'h1, {31'h0, functionEnable});
    $display("test irq done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
